// [rtl/fpc_top.sv]
// Purpose: flash protection controller between core and flash array
// Assumes: flash array obeys the request held on O_FLASH_REQ
// Notes:   core is held while booting and while any flash job runs
`timescale 1ns/1ps
`default_nettype none
module fpc_top #(
  parameter logic [31:0] P_CYC_ERASE_PAGE = fpc_pkg::CYC_ERASE_PAGE,
  parameter logic [31:0] P_CYC_ERASE_ALL  = fpc_pkg::CYC_ERASE_ALL
) (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_N,
  input  wire fpc_pkg::fpc_sfr_req_type   I_SFR,
  output fpc_pkg::fpc_flash_req_type      O_FLASH_REQ,
  input  wire logic [7:0]                 I_FLASH_RDATA,
  input  wire logic                       I_SERIAL_DOWNLOAD_ENABLE_N,
  input  wire fpc_pkg::fpc_dl_cmd_type    I_DL_CMD,
  output logic [7:0]                      O_SFR_RDATA,
  output logic                            O_CORE_HOLD,
  output logic                            O_DOWNLOAD_MODE,
  output logic                            O_PROT_ACTIVE,
  output logic                            O_WDT_LOCK_EN,
  output logic                            O_CMD_REFUSED
);

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    ST_BOOT    = 4'b0001,
    ST_BOOT_RD = 4'b0010,
    ST_IDLE    = 4'b0100,
    ST_OP      = 4'b1000
  } fpc_state_type;

  fpc_state_type state;
  logic [7:0]  flash_command;
  logic [7:0]  flash_access_key;
  logic [7:0]  protection_key_entry;
  logic [7:0]  flash_data_pointer;
  logic [7:0]  flash_address_low;
  logic [7:0]  flash_address_high;
  logic [7:0]  working_register_zero;
  logic [20:0][7:0] act_img;
  logic [20:0][7:0] live_img;
  logic [4:0]  boot_idx;
  logic        strap_taken;
  logic        tmr_load;
  logic [31:0] tmr_cycles;
  logic        tmr_done;

  // ==========================================================
  // helpers
  function automatic logic page_wp(input logic [20:0][7:0] img,
                                   input logic [6:0] pg);
    page_wp = ~img[5'(fpc_pkg::IMG_WP_BASE + 5'(pg[6:3]))][pg[2:0]];
  endfunction

  function automatic logic page_rp(input logic [20:0][7:0] img,
                                   input logic [6:0] pg);
    page_rp = ~img[5'(fpc_pkg::IMG_RP_BASE + 5'(pg[6:5]))][pg[4:2]];
  endfunction

  // ==========================================================
  // sfr source: core or download kernel
  logic        dl_store;
  logic        sfr_wr;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  always_comb begin
    dl_store = O_DOWNLOAD_MODE && I_DL_CMD.valid &&
               I_DL_CMD.cmd == fpc_pkg::DL_STORE_R0;
    sfr_wr    = dl_store || I_SFR.wr;
    sfr_addr  = dl_store ? I_DL_CMD.data : I_SFR.addr;
    sfr_wdata = dl_store ? working_register_zero : I_SFR.wdata;
  end

  // ==========================================================
  // command decode
  logic [15:0] full_addr;
  logic [6:0]  page;
  logic        active;
  logic        cmd_wr;
  logic        key_ok;
  logic        prot_key_ok;
  logic        accept;
  fpc_pkg::fpc_op_type next_op;
  logic [31:0] next_cycles;
  always_comb begin
    full_addr  = {flash_address_high, flash_address_low};
    page       = full_addr[15:fpc_pkg::PAGE_LSB];
    active     = page_wp(act_img, fpc_pkg::LAST_PAGE);
    cmd_wr     = sfr_wr && sfr_addr == fpc_pkg::SFR_FLASH_COMMAND &&
                 state == ST_IDLE;
    key_ok     = flash_access_key == fpc_pkg::ACCESS_KEY;
    prot_key_ok = act_img[fpc_pkg::IMG_KEY] == fpc_pkg::ERASED ||
                  protection_key_entry == act_img[fpc_pkg::IMG_KEY];
    accept      = 1'b0;
    next_op     = fpc_pkg::OP_NONE;
    next_cycles = fpc_pkg::CYC_WRITE;
    case (sfr_wdata)
      fpc_pkg::CMD_WRITE_BYTE: begin
        accept  = key_ok && !(active && page_wp(act_img, page)) &&
                  full_addr < fpc_pkg::PROT_BASE;
        next_op = fpc_pkg::OP_WRITE;
        next_cycles = fpc_pkg::CYC_WRITE;
      end
      fpc_pkg::CMD_ERASE_PAGE: begin
        accept  = key_ok && !(active && page_wp(act_img, page));
        next_op = fpc_pkg::OP_ERASE_PAGE;
        next_cycles = P_CYC_ERASE_PAGE;
      end
      fpc_pkg::CMD_ERASE_ALL: begin
        accept  = key_ok;
        next_op = fpc_pkg::OP_ERASE_ALL;
        next_cycles = P_CYC_ERASE_ALL;
      end
      fpc_pkg::CMD_READ_BYTE: begin
        accept  = key_ok && (!(active && page_rp(act_img, page)) ||
                  full_addr >= fpc_pkg::PROT_BASE);
        next_op = fpc_pkg::OP_READ;
        next_cycles = fpc_pkg::CYC_READ;
      end
      fpc_pkg::CMD_PROTECT: begin
        accept  = key_ok && prot_key_ok &&
                  flash_address_low >= fpc_pkg::PROT_KEY_LOW &&
                  !(flash_address_low == fpc_pkg::PROT_KEY_LOW &&
                    live_img[fpc_pkg::IMG_KEY] != fpc_pkg::ERASED) &&
                  !(O_DOWNLOAD_MODE && active);
        next_op = fpc_pkg::OP_WRITE;
        next_cycles = fpc_pkg::CYC_WRITE;
      end
      default: begin
        accept  = 1'b0;
      end
    endcase
  end

  logic [4:0] prot_idx;
  assign prot_idx = 5'(flash_address_low - fpc_pkg::PROT_KEY_LOW);

  // ==========================================================
  // timer
  assign tmr_load   = (state == ST_BOOT) || (cmd_wr && accept);
  assign tmr_cycles = (state == ST_BOOT) ? fpc_pkg::CYC_READ : next_cycles;

  fpc_timer u_timer (
    .i_clk    (I_CLK),
    .i_rst_n  (I_RST_N),
    .i_load   (tmr_load),
    .i_cycles (tmr_cycles),
    .o_busy   (),
    .o_done   (tmr_done)
  );

  // ==========================================================
  // sequencer and flash request
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state       <= ST_BOOT;
      boot_idx    <= fpc_pkg::IMG_KEY;
      O_FLASH_REQ <= '0;
      O_CORE_HOLD <= 1'b1;
    end else begin
      case (state)
        ST_BOOT: begin
          O_FLASH_REQ <= '{fpc_pkg::OP_READ,
                           16'(fpc_pkg::PROT_BASE + 16'(boot_idx)),
                           fpc_pkg::RST_ZERO};
          O_CORE_HOLD <= 1'b1;
          state       <= ST_BOOT_RD;
        end
        ST_BOOT_RD: begin
          if (tmr_done) begin
            O_FLASH_REQ <= '0;
            if (boot_idx == fpc_pkg::IMG_LAST) begin
              state       <= ST_IDLE;
              O_CORE_HOLD <= 1'b0;
            end else begin
              boot_idx <= 5'(boot_idx + 5'd1);
              state    <= ST_BOOT;
            end
          end
        end
        ST_IDLE: begin
          if (cmd_wr && accept) begin
            O_CORE_HOLD <= 1'b1;
            state       <= ST_OP;
            if (sfr_wdata == fpc_pkg::CMD_PROTECT) begin
              O_FLASH_REQ <= '{next_op,
                               {fpc_pkg::PROT_HIGH, flash_address_low},
                               live_img[prot_idx] & flash_data_pointer};
            end else begin
              O_FLASH_REQ <= '{next_op, full_addr, flash_data_pointer};
            end
          end
        end
        ST_OP: begin
          if (tmr_done) begin
            O_FLASH_REQ <= '0;
            O_CORE_HOLD <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  // ==========================================================
  // protection images
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      act_img  <= {21{fpc_pkg::ERASED}};
      live_img <= {21{fpc_pkg::ERASED}};
    end else if (state == ST_BOOT_RD && tmr_done) begin
      act_img[boot_idx]  <= I_FLASH_RDATA;
      live_img[boot_idx] <= I_FLASH_RDATA;
    end else if (state == ST_IDLE && cmd_wr && accept) begin
      if (sfr_wdata == fpc_pkg::CMD_PROTECT) begin
        live_img[prot_idx] <= live_img[prot_idx] & flash_data_pointer;
      end else if (sfr_wdata == fpc_pkg::CMD_ERASE_ALL) begin
        live_img <= {21{fpc_pkg::ERASED}};
      end
    end
  end

  // ==========================================================
  // enforcement outputs and strap
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_PROT_ACTIVE   <= 1'b0;
      O_WDT_LOCK_EN   <= 1'b0;
      O_DOWNLOAD_MODE <= 1'b0;
      strap_taken     <= 1'b0;
    end else begin
      O_PROT_ACTIVE <= active;
      O_WDT_LOCK_EN <= ~act_img[fpc_pkg::IMG_WDT_BYTE][fpc_pkg::WDT_BIT];
      if (!strap_taken) begin
        O_DOWNLOAD_MODE <= ~I_SERIAL_DOWNLOAD_ENABLE_N;
        strap_taken     <= 1'b1;
      end
    end
  end

  // ==========================================================
  // special function registers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      flash_command         <= fpc_pkg::RST_ZERO;
      flash_access_key      <= fpc_pkg::RST_KEY;
      protection_key_entry  <= fpc_pkg::RST_KEY;
      flash_data_pointer    <= fpc_pkg::RST_ZERO;
      flash_address_low     <= fpc_pkg::RST_ZERO;
      flash_address_high    <= fpc_pkg::RST_ZERO;
      working_register_zero <= fpc_pkg::RST_ZERO;
      O_CMD_REFUSED         <= 1'b0;
    end else begin
      if (O_DOWNLOAD_MODE && I_DL_CMD.valid &&
          I_DL_CMD.cmd == fpc_pkg::DL_LOAD_R0) begin
        working_register_zero <= I_DL_CMD.data;
      end
      if (state == ST_OP && tmr_done && O_FLASH_REQ.op == fpc_pkg::OP_READ) begin
        flash_data_pointer <= I_FLASH_RDATA;
      end
      if (cmd_wr) begin
        flash_command    <= sfr_wdata;
        flash_access_key <= fpc_pkg::RST_KEY;
        O_CMD_REFUSED    <= ~accept;
        if (sfr_wdata == fpc_pkg::CMD_PROTECT) begin
          protection_key_entry <= fpc_pkg::RST_ZERO;
        end
      end else if (sfr_wr && state == ST_IDLE) begin
        if (sfr_addr == fpc_pkg::SFR_FLASH_ACCESS_KEY) begin
          flash_access_key <= sfr_wdata;
        end else if (sfr_addr == fpc_pkg::SFR_PROT_KEY_ENTRY) begin
          protection_key_entry <= sfr_wdata;
        end else if (sfr_addr == fpc_pkg::SFR_FLASH_DATA) begin
          flash_data_pointer <= sfr_wdata;
        end else if (sfr_addr == fpc_pkg::SFR_FLASH_ADDR_LOW) begin
          flash_address_low <= sfr_wdata;
        end else if (sfr_addr == fpc_pkg::SFR_FLASH_ADDR_HIGH) begin
          flash_address_high <= sfr_wdata;
        end
      end
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_SFR_RDATA <= fpc_pkg::RST_ZERO;
    end else if (I_SFR.rd) begin
      if (I_SFR.addr == fpc_pkg::SFR_FLASH_COMMAND) begin
        O_SFR_RDATA <= flash_command;
      end else if (I_SFR.addr == fpc_pkg::SFR_FLASH_ACCESS_KEY) begin
        O_SFR_RDATA <= flash_access_key;
      end else if (I_SFR.addr == fpc_pkg::SFR_PROT_KEY_ENTRY) begin
        O_SFR_RDATA <= protection_key_entry;
      end else if (I_SFR.addr == fpc_pkg::SFR_FLASH_DATA) begin
        O_SFR_RDATA <= flash_data_pointer;
      end else if (I_SFR.addr == fpc_pkg::SFR_FLASH_ADDR_LOW) begin
        O_SFR_RDATA <= flash_address_low;
      end else if (I_SFR.addr == fpc_pkg::SFR_FLASH_ADDR_HIGH) begin
        O_SFR_RDATA <= flash_address_high;
      end else begin
        O_SFR_RDATA <= fpc_pkg::RST_ZERO;
      end
    end
  end

endmodule // fpc_top
`default_nettype wire

// [rtl/fpc_pkg.sv]
// Purpose: constants and types of the flash protection controller
// Assumes: 40 MHz core clock, 8-bit special function register bus
// Notes:   protection image is 21 bytes at the top of the flash array
package fpc_pkg;

  // ==========================================================
  // special function register addresses
  localparam logic [7:0] SFR_FLASH_COMMAND   = 8'hb9;
  localparam logic [7:0] SFR_FLASH_ACCESS_KEY = 8'hba;
  localparam logic [7:0] SFR_PROT_KEY_ENTRY  = 8'hbb;
  localparam logic [7:0] SFR_FLASH_DATA      = 8'hbc;
  localparam logic [7:0] SFR_FLASH_ADDR_LOW  = 8'hc6;
  localparam logic [7:0] SFR_FLASH_ADDR_HIGH = 8'hc7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_KEY  = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] ERASED   = 8'hff;

  // ==========================================================
  // commands and keys
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h03;
  localparam logic [7:0] CMD_READ_BYTE  = 8'h04;
  localparam logic [7:0] CMD_PROTECT    = 8'h08;
  localparam logic [7:0] ACCESS_KEY     = 8'h3b;
  localparam logic [7:0] DL_LOAD_R0     = 8'h49;
  localparam logic [7:0] DL_STORE_R0    = 8'h46;

  // ==========================================================
  // protection image layout
  localparam logic [7:0] PROT_HIGH     = 8'hf7;
  localparam logic [7:0] PROT_KEY_LOW  = 8'heb;
  localparam logic [7:0] PROT_WP_LOW   = 8'hf0;
  localparam logic [4:0] IMG_LAST      = 5'd20;
  localparam logic [4:0] IMG_KEY       = 5'd0;
  localparam logic [4:0] IMG_RP_BASE   = 5'd1;
  localparam logic [4:0] IMG_WP_BASE   = 5'd5;
  localparam logic [4:0] IMG_WDT_BYTE  = 5'd20;
  localparam int         WDT_BIT       = 7;
  localparam logic [6:0] LAST_PAGE     = 7'd123;
  localparam int         PAGE_LSB      = 9;
  localparam logic [15:0] PROT_BASE    = 16'hf7eb;

  // ==========================================================
  // timing
  localparam longint CLK_PERIOD_NS   = 25;
  localparam longint T_WRITE_NS      = 30000;
  localparam longint T_ERASE_PAGE_NS = 20000000;
  localparam longint T_ERASE_ALL_NS  = 64'd2500000000;
  localparam longint T_READ_NS       = 100;
  localparam logic [31:0] CYC_WRITE =
    32'((T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] CYC_ERASE_PAGE =
    32'((T_ERASE_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] CYC_ERASE_ALL =
    32'((T_ERASE_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [31:0] CYC_READ =
    32'((T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_WRITE = 3'h1,
    OP_ERASE_PAGE = 3'h2,
    OP_ERASE_ALL  = 3'h3,
    OP_READ  = 3'h4
  } fpc_op_type;

  typedef struct packed {
    fpc_op_type  op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpc_flash_req_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpc_sfr_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] cmd;
    logic [7:0] data;
  } fpc_dl_cmd_type;

endpackage

// [rtl/fpc_timer.sv]
// Purpose: flash operation duration counter
// Assumes: load and count are synchronous to the core clock
// Notes:   done pulses for one cycle, i_cycles clocks after the load
`timescale 1ns/1ps
`default_nettype none
module fpc_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_load,
  input  wire logic [31:0] i_cycles,
  output logic             o_busy,
  output logic             o_done
);

  // ==========================================================
  // countdown
  logic [31:0] count;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count  <= 32'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        count  <= i_cycles;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count <= 32'h1) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end

endmodule // fpc_timer
`default_nettype wire

// [tb/fpc_props.sv]
// Purpose: port assertions for the flash protection controller
// Assumes: sees only the ports of fpc_top
// Notes:   helper logic mirrors the access key and address low registers
`timescale 1ns/1ps
`default_nettype none
module fpc_props #(
  parameter logic [31:0] P_CYC_ERASE_PAGE = 32'd20,
  parameter logic [31:0] P_CYC_ERASE_ALL  = 32'd30
) (
  input wire logic                       I_CLK,
  input wire logic                       I_RST_N,
  input wire fpc_pkg::fpc_sfr_req_type   I_SFR,
  input wire fpc_pkg::fpc_flash_req_type O_FLASH_REQ,
  input wire logic                       O_CORE_HOLD,
  input wire logic                       O_DOWNLOAD_MODE,
  input wire logic                       O_PROT_ACTIVE,
  input wire logic                       O_WDT_LOCK_EN,
  input wire logic                       O_CMD_REFUSED
);
  // ==========================================================
  // helper logic
  logic [7:0]  key_q;
  logic [7:0]  low_q;
  logic [11:0] run_q;
  logic        take;
  logic        cmd_wr;
  logic        prot_wr;
  assign take    = I_SFR.wr && !O_CORE_HOLD;
  assign cmd_wr  = take && I_SFR.addr == fpc_pkg::SFR_FLASH_COMMAND;
  assign prot_wr = cmd_wr && I_SFR.wdata == fpc_pkg::CMD_PROTECT;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || cmd_wr) key_q <= 8'hff;
    else if (take && I_SFR.addr == fpc_pkg::SFR_FLASH_ACCESS_KEY)
      key_q <= I_SFR.wdata;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) low_q <= 8'h00;
    else if (take && I_SFR.addr == fpc_pkg::SFR_FLASH_ADDR_LOW)
      low_q <= I_SFR.wdata;
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || O_FLASH_REQ.op == fpc_pkg::OP_NONE) run_q <= 12'h000;
    else run_q <= run_q + 12'h001;
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // ==========================================================
  // assertions
  a_reset_state: assert property (disable iff (1'b0) !I_RST_N |=>
    O_CORE_HOLD && O_FLASH_REQ.op == fpc_pkg::OP_NONE)
    else $error("state wrong during reset");
  a_key_gate: assert property (cmd_wr && key_q != 8'h3b |=>
    O_CMD_REFUSED && O_FLASH_REQ.op == fpc_pkg::OP_NONE)
    else $error("command ran without access key");
  a_prot_addr: assert property (prot_wr |=> O_CMD_REFUSED ||
    (O_FLASH_REQ.op == fpc_pkg::OP_WRITE && O_FLASH_REQ.addr == {8'hf7, low_q}))
    else $error("protect command wrong request");
  a_low_range: assert property (prot_wr && low_q < 8'heb |=>
    O_CMD_REFUSED && O_FLASH_REQ.op == fpc_pkg::OP_NONE)
    else $error("protect outside area not refused");
  a_hold_busy: assert property (O_FLASH_REQ.op != fpc_pkg::OP_NONE
    |-> O_CORE_HOLD) else $error("core not held during flash op");
  a_write_len: assert property (O_FLASH_REQ.op == fpc_pkg::OP_WRITE
    |-> run_q <= 12'd1200) else $error("byte write too long");
  a_write_full: assert property (O_FLASH_REQ.op == fpc_pkg::OP_WRITE ##1
    O_FLASH_REQ.op != fpc_pkg::OP_WRITE |-> $past(run_q) >= 12'd1198)
    else $error("byte write too short");
  a_read_len: assert property (O_FLASH_REQ.op == fpc_pkg::OP_READ
    |-> run_q < 12'd8) else $error("byte read too long");
  a_refused_idle: assert property ($rose(O_CMD_REFUSED) |->
    O_FLASH_REQ.op == fpc_pkg::OP_NONE) else $error("refused but flash busy");
  a_prot_frozen: assert property ($changed(O_PROT_ACTIVE) |->
    $past(O_CORE_HOLD) || $past(O_CORE_HOLD, 2))
    else $error("protection changed outside boot");
  a_wdt_frozen: assert property ($changed(O_WDT_LOCK_EN) |->
    $past(O_CORE_HOLD) || $past(O_CORE_HOLD, 2))
    else $error("watchdog lock changed outside boot");
  a_mode_strap: assert property ($changed(O_DOWNLOAD_MODE) |->
    !$past(I_RST_N) || !$past(I_RST_N, 2))
    else $error("download mode changed outside reset");
  c_prot_ok: cover property (prot_wr ##1 !O_CMD_REFUSED);
  c_prot_bad: cover property (prot_wr ##1 O_CMD_REFUSED);
  c_download: cover property ($rose(O_DOWNLOAD_MODE));
endmodule // fpc_props
bind fpc_top fpc_props #(.P_CYC_ERASE_PAGE(P_CYC_ERASE_PAGE),
  .P_CYC_ERASE_ALL(P_CYC_ERASE_ALL)) u_fpc_props (.I_CLK, .I_RST_N, .I_SFR,
  .O_FLASH_REQ, .O_CORE_HOLD, .O_DOWNLOAD_MODE, .O_PROT_ACTIVE,
  .O_WDT_LOCK_EN, .O_CMD_REFUSED);
`default_nettype wire

// [tb/fpc_flash_model.sv]
// Purpose: behavioural flash array behind the controller
// Assumes: one request held on i_req per operation
// Notes:   read data toggles when no read is in progress
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model (
  input  wire logic                       i_clk,
  input  wire fpc_pkg::fpc_flash_req_type i_req,
  output logic [7:0]                      o_rdata
);
  logic [7:0]          mem [int];
  fpc_pkg::fpc_op_type last_op = fpc_pkg::OP_NONE;
  initial o_rdata = 8'h5a;
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  always @(posedge i_clk) begin
    last_op <= i_req.op;
    o_rdata <= (i_req.op == fpc_pkg::OP_READ) ? rd(int'(i_req.addr))
                                               : ~o_rdata;
    if (i_req.op != last_op) begin
      case (i_req.op)
        fpc_pkg::OP_WRITE:
          mem[int'(i_req.addr)] = rd(int'(i_req.addr)) & i_req.wdata;
        fpc_pkg::OP_ERASE_PAGE: for (int i = 0; i < 512; i++) begin
          mem.delete({i_req.addr[15:9], 9'h000} + i);
        end
        fpc_pkg::OP_ERASE_ALL: mem.delete();
        default: ;
      endcase
    end
  end
endmodule // fpc_flash_model
`default_nettype wire

// [tb/fpc_bench.sv]
// Purpose: self-checking bench of the flash protection controller
// Assumes: flash model keeps its contents across resets
// Notes:   erase times shortened through the top parameters
`timescale 1ns/1ps
`default_nettype none
module fpc_bench;
  logic clk, rst_n, serial_download_enable_n_n, hold, dlm, pact, wdt, refd;
  logic [7:0] frd, srd, v, d;
  fpc_pkg::fpc_sfr_req_type   sfr;
  fpc_pkg::fpc_dl_cmd_type    dl;
  fpc_pkg::fpc_flash_req_type freq;
  int errors, checks_done, cyc;
  int img[21], lat[21];
  bit dlmode;
  fpc_top #(.P_CYC_ERASE_PAGE(32'd20), .P_CYC_ERASE_ALL(32'd30)) u_fpc_top (
    .I_CLK(clk), .I_RST_N(rst_n), .I_SFR(sfr), .O_FLASH_REQ(freq),
    .I_FLASH_RDATA(frd), .I_SERIAL_DOWNLOAD_ENABLE_N(serial_download_enable_n_n), .I_DL_CMD(dl),
    .O_SFR_RDATA(srd), .O_CORE_HOLD(hold), .O_DOWNLOAD_MODE(dlm),
    .O_PROT_ACTIVE(pact), .O_WDT_LOCK_EN(wdt), .O_CMD_REFUSED(refd));
  fpc_flash_model u_fpc_flash_model (.i_clk(clk), .i_req(freq), .o_rdata(frd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dd);
    @(posedge clk); #2 sfr = '{1'b1, 1'b0, a, dd};
    @(posedge clk); #2 sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk); #2 sfr = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk); #2 sfr.rd = 1'b0;
    q = srd;
  endtask
  task automatic wait_idle(input int lim);
    int n;
    for (n = 0; hold !== 1'b0 && n < lim; n++) begin
      @(posedge clk);
      #2;
    end
    if (n == lim) errors++;
  endtask
  task automatic cmd(input logic [7:0] c, input bit bad);
    wr(8'hb9, c);
    wait_idle(3000);
    check(8'(refd), 8'(bad));
  endtask
  task automatic boot(input bit sd);
    @(posedge clk); #2 rst_n = 1'b0;
    serial_download_enable_n_n = sd;
    repeat (6) @(posedge clk);
    #2 rst_n = 1'b1;
    wait_idle(400);
    @(posedge clk);
    #2 lat = img;
    dlmode = !sd;
    check(8'(dlm), 8'(dlmode));
    check(8'(pact), 8'(lat[20][3] == 0));
    check(8'(wdt), 8'(lat[20][7] == 0));
  endtask
  task automatic prot(input int low, input int dd, input int k, input int ak);
    int i;
    bit act, bad;
    i = low - 'heb;
    act = lat[20][3] == 0;
    bad = ak != 'h3b || low < 'heb || (lat[0] != 'hff && k != lat[0])
      || (i == 0 && img[0] != 'hff) || (dlmode && act);
    wr(8'hbc, dd[7:0]);
    wr(8'hc6, low[7:0]);
    wr(8'hbb, k[7:0]);
    wr(8'hba, ak[7:0]);
    cmd(8'h08, bad);
    if (!bad) img[i] &= dd;
    rd(8'hbb, v);
    check(v, 8'h00);
    if (i >= 0) check(u_fpc_flash_model.rd('hf700 + low), 8'(img[i]));
  endtask
  task automatic op(input int hi, input int lo, input int c);
    int p;
    bit act, bad;
    p = (hi * 256 + lo) / 512;
    act = lat[20][3] == 0;
    bad = (act && (c == 1 || c == 2) && lat[5 + p / 8][p % 8] == 0)
      || (c == 1 && hi == 'hf7 && lo >= 'heb);
    wr(8'hc7, hi[7:0]);
    wr(8'hc6, lo[7:0]);
    wr(8'hba, 8'h3b);
    cmd(c[7:0], bad);
  endtask
  initial begin
    rst_n = 1'b0;
    serial_download_enable_n_n = 1'b1;
    sfr = '0;
    dl = '0;
    foreach (img[i]) img[i] = 'hff;
    void'($urandom(40));
    boot(1'b1);
    d = 8'($urandom);
    wr(8'hbc, d);
    rd(8'hbc, v);
    check(v, d);
    rd(8'h80, v);
    check(v, 8'h00);
    $display("test registers done");
    prot('hf0, 'hfe, 0, 'h00);
    prot('he0, 'h00, 0, 'h3b);
    prot('hf0, 'hfe, 0, 'h3b);
    prot('hff, 'h77, 0, 'h3b);
    prot('heb, 'ha3, 0, 'h3b);
    prot('heb, 'h11, 0, 'h3b);
    check(8'(pact), 8'h00);
    $display("test programming done");
    boot(1'b1);
    prot('hf1, $urandom, 0, 'h3b);
    prot('hf0, 'hff, 'ha3, 'h3b);
    op('h00, 'h10, 1);
    op('hee, 'h00, 1);
    op('h00, 'h00, 2);
    op('hee, 'h00, 2);
    op('hf7, 'hf0, 4);
    rd(8'hbc, v);
    check(v, 8'hfe);
    $display("test enforcement done");
    boot(1'b0);
    @(posedge clk); #2 dl = '{1'b1, 8'h49, 8'h5c};
    @(posedge clk); #2 dl = '{1'b1, 8'h46, 8'hbc};
    @(posedge clk); #2 dl.valid = 1'b0;
    rd(8'hbc, v);
    check(v, 8'h5c);
    prot('hf2, 'h00, 'ha3, 'h3b);
    op('h00, 'h00, 3);
    foreach (img[i]) img[i] = 'hff;
    boot(1'b1);
    $display("test download done");
    wrap_up();
  end
endmodule // fpc_bench
`default_nettype wire
